// *** src/bdt_pkg.sv ***
// Purpose: shared constants and carrier types for the two-bearer plus signalling TDM port
// Assumes: system clock at 25 MHz; all pin timing is recovered by sampling
// Notes: bit positions count from zero at the first bit after frame sync
//
// Operation
// - format one: bearer one, bearer two, two signalling bits in bits 0-17
// - format one with signalling port: signalling bits 16-17 go on that port
// - format two: bearer one, signalling, ignored bit, bearer two, signalling
// - format three: each bearer in any of 64 byte slots, tx and rx independent
// - format three: signalling in any of 256 two-bit slots, main or port pins
// - format four: bearer one, bearer two, eight ignored, two signalling bits
// - format four master drives 512 kHz bit clock and square frame sync a; code divides 25 MHz by 48, about 520.8 kHz
// - non-delayed mode: frame sync spans the eight bits of its slot
// - delayed mode: frame sync only marks the start of the first slot
// - sample transmit on falling clock edges, drive receive on rising edges
// - network end: open-drain slot strobe low in receive bearer slots only
// - subscriber master: sync a marks bearer one, sync b bearer two, clock out
// - non-delayed after reset; delayed chosen before slot assignment is used
// - new slot assignment takes effect on second frame after control access
// - signalling port shifted by free 16 kHz clock or by the bit clock
// - format three: signalling pairs at bits 0-1, 2-3, 4-5 or 6-7 of slot
// - signalling slot assignment unavailable with the 16 kHz port clock
// - format two slave: delayed timing only, no slot assignment
// - master: transmit and receive frames always aligned
// - programmable bearer slots only honoured in format three
// - three-frame elastic buffer each way; overrun or underrun slips one frame
// - control write is sixteen clocks then chip select high, then loaded

package bdt_pkg;

	// ---------------------------------------------------------------
	// clocking
	// ---------------------------------------------------------------
	localparam int CLK_SYS_KHZ = 25000;
	localparam int MASTER_BCLK_KHZ = 512;
	localparam int FRAME_KHZ = 8;
	localparam int SIG_CLK_KHZ = 16;
	localparam int MASTER_HALF = CLK_SYS_KHZ / (2 * MASTER_BCLK_KHZ);
	localparam int SIG_HALF = CLK_SYS_KHZ / (2 * SIG_CLK_KHZ);
	localparam int MASTER_FRAME_BITS = MASTER_BCLK_KHZ / FRAME_KHZ;
	localparam logic [4:0] MASTER_HALF_M1 = 5'(MASTER_HALF - 1);
	localparam logic [9:0] SIG_HALF_M1 = 10'(SIG_HALF - 1);
	localparam logic [8:0] MASTER_LAST = 9'(MASTER_FRAME_BITS - 1);
	localparam logic [8:0] MASTER_SQUARE = 9'(MASTER_FRAME_BITS / 2);
	localparam logic [8:0] POS_MAX = 9'h1ff;

	// ---------------------------------------------------------------
	// formats and bit positions
	// ---------------------------------------------------------------
	localparam logic [1:0] FMT_ONE = 2'h0;
	localparam logic [1:0] FMT_TWO = 2'h1;
	localparam logic [1:0] FMT_THREE = 2'h2;
	localparam logic [1:0] FMT_FOUR = 2'h3;
	localparam logic [8:0] SLOT_BITS = 9'h008;
	localparam logic [8:0] F1_B2 = 9'h008;
	localparam logic [8:0] F1_SIG = 9'h010;
	localparam logic [8:0] F1_END = 9'h012;
	localparam logic [8:0] F2_SIG1 = 9'h008;
	localparam logic [8:0] F2_B2 = 9'h00a;
	localparam logic [8:0] F2_SIG2 = 9'h012;
	localparam logic [8:0] F4_B2 = 9'h008;
	localparam logic [8:0] F4_GAP = 9'h010;
	localparam logic [8:0] F4_SIG = 9'h018;
	localparam logic [8:0] F4_END = 9'h01a;

	// ---------------------------------------------------------------
	// slot assignment writes
	// ---------------------------------------------------------------
	localparam logic [2:0] SEL_TX_B1 = 3'h0;
	localparam logic [2:0] SEL_TX_B2 = 3'h1;
	localparam logic [2:0] SEL_RX_B1 = 3'h2;
	localparam logic [2:0] SEL_RX_B2 = 3'h3;
	localparam logic [2:0] SEL_TX_SIG = 3'h4;
	localparam logic [2:0] SEL_RX_SIG = 3'h5;
	localparam logic [1:0] APPLY_FRAMES = 2'h2;

	localparam int EB_DEPTH = 3;
	localparam int PIN_W = 5;

	typedef struct packed {
		logic [1:0] fmt;
		logic master;
		logic delayed;
		logic sig_port_en;
		logic sig_port_bclk;
		logic network_end;
	} bdt_cfg_t;

	typedef struct packed {
		logic valid;
		logic [2:0] sel;
		logic [7:0] value;
	} bdt_slot_wr_t;

	typedef struct packed {
		logic [5:0] tx_b1;
		logic [5:0] tx_b2;
		logic [5:0] rx_b1;
		logic [5:0] rx_b2;
		logic [7:0] tx_sig;
		logic [7:0] rx_sig;
	} bdt_slots_t;

	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] sig;
	} bdt_frame_t;

	typedef struct packed {
		logic b1;
		logic b2;
		logic sigm;
		logic sigp;
		logic [2:0] idx;
		logic sidx;
	} bdt_hit_t;

	localparam bdt_slots_t SLOTS_RST = '{tx_b1: 6'h00, tx_b2: 6'h01, rx_b1: 6'h00,
		rx_b2: 6'h01, tx_sig: 8'h08, rx_sig: 8'h08};

endpackage

// *** src/bdt_sync2.sv ***
// Purpose: two-stage synchroniser for the sampled serial pins
// Assumes: inputs are asynchronous to clk_sys
// Notes: only the second stage leaves this module
`timescale 1ns/1ns
module bdt_sync2
	import bdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [PIN_W-1:0] async_in,
	output logic [PIN_W-1:0] sync_out
);

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
	} bdt_sync_state_t;

	bdt_sync_state_t s_reg;
	bdt_sync_state_t s_next;

	always_comb begin
		s_next.s1 = async_in;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.s2;

endmodule

// *** src/bdt_elastic.sv ***
// Purpose: three-frame elastic store between serial port and line side
// Assumes: push and pop are single-cycle pulses on clk_sys
// Notes: head holds the last popped frame and repeats it on underrun
`timescale 1ns/1ns
module bdt_elastic
	import bdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic push,
	input wire bdt_frame_t push_data,
	input wire logic pop,
	output bdt_frame_t head,
	output logic slip
);

	typedef struct packed {
		bdt_frame_t [EB_DEPTH-1:0] mem;
		logic [1:0] wr;
		logic [1:0] rd;
		logic [1:0] cnt;
		bdt_frame_t head;
		logic slip;
	} bdt_eb_state_t;

	bdt_eb_state_t s_reg;
	bdt_eb_state_t s_next;

	function automatic logic [1:0] inc(input logic [1:0] p);
		inc = (p == 2'(EB_DEPTH - 1)) ? 2'h0 : p + 2'h1;
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.slip = 1'b0;
		if (pop) begin
			if (s_reg.cnt != 2'h0) begin
				s_next.head = s_reg.mem[s_reg.rd];
				s_next.rd = inc(s_reg.rd);
				s_next.cnt = s_next.cnt - 2'h1;
			end else begin
				s_next.slip = 1'b1;
			end
		end
		if (push) begin
			if (s_next.cnt == 2'(EB_DEPTH)) begin
				s_next.rd = inc(s_next.rd);
				s_next.cnt = s_next.cnt - 2'h1;
				s_next.slip = 1'b1;
			end
			s_next.mem[s_reg.wr] = push_data;
			s_next.wr = inc(s_reg.wr);
			s_next.cnt = s_next.cnt + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign head = s_reg.head;
	assign slip = s_reg.slip;

endmodule

// *** src/bdt_port.sv ***
// Purpose: serial time-slot engine for two bearers and one signalling channel
// Assumes: cfg, slot_wr and line_tick are on clk_sys; all pins are asynchronous
// Notes: slave bit clock is edge-detected from samples, so it must stay well
//        below a quarter of clk_sys
`timescale 1ns/1ns
module bdt_port
	import bdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire bdt_cfg_t cfg,
	input wire bdt_slot_wr_t slot_wr,
	input wire logic bit_clock_in,
	output logic bit_clock_out,
	output logic bit_clock_oe,
	input wire logic frame_sync_a_in,
	output logic frame_sync_a_out,
	output logic frame_sync_a_oe,
	input wire logic frame_sync_b_in,
	output logic frame_sync_b_out,
	output logic frame_sync_b_oe,
	input wire logic bearer_tx_in,
	output logic bearer_rx_out,
	output logic bearer_rx_oe,
	output logic rx_slot_strobe_out,
	output logic rx_slot_strobe_oe,
	input wire logic sig_tx_in,
	output logic sig_rx_out,
	output logic sig_rx_oe,
	output logic sig_port_clock_out,
	output logic sig_port_clock_oe,
	input wire logic line_tick,
	input wire bdt_frame_t line_rx_word,
	output bdt_frame_t line_tx_word,
	output logic tx_slip,
	output logic rx_slip
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] bdiv;
		logic bclk_o;
		logic bclk_oe;
		logic bclk_prev;
		logic fsa_r;
		logic fsb_r;
		logic fsa_f1;
		logic fsa_f2;
		logic fsb_f1;
		logic fsb_f2;
		logic fsa_o;
		logic fsb_o;
		logic fs_oe;
		logic [8:0] tx_pos;
		logic [8:0] rx_pos;
		logic tx_run;
		logic rx_run;
		bdt_frame_t tx_word;
		bdt_frame_t tx_out;
		bdt_frame_t rx_word;
		logic tx_push;
		logic rx_pop;
		logic brx_o;
		logic brx_oe;
		logic strobe_o;
		logic strobe_oe;
		logic srx_o;
		logic srx_oe;
		logic [9:0] sdiv;
		logic sclk_o;
		logic sclk_oe;
		logic sbit;
		bdt_slots_t act;
		bdt_slots_t shd;
		logic [1:0] pend;
	} bdt_state_t;

	typedef struct packed {
		logic bclk;
		logic frame_sync_a;
		logic frame_sync_b;
		logic btx;
		logic stx;
	} bdt_pins_t;

	bdt_state_t s_reg;
	bdt_state_t s_next;
	bdt_pins_t pin;
	bdt_frame_t rx_head;

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	bdt_sync2 u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({bit_clock_in, frame_sync_a_in, frame_sync_b_in, bearer_tx_in, sig_tx_in}),
		.sync_out(pin)
	);

	bdt_elastic u_tx_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(s_reg.tx_push),
		.push_data(s_reg.tx_out),
		.pop(line_tick),
		.head(line_tx_word),
		.slip(tx_slip)
	);

	bdt_elastic u_rx_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(line_tick),
		.push_data(line_rx_word),
		.pop(s_reg.rx_pop),
		.head(rx_head),
		.slip(rx_slip)
	);

	// ---------------------------------------------------------------
	// bit position to channel map
	// ---------------------------------------------------------------
	function automatic bdt_hit_t map_pos(input logic [8:0] pos, input bdt_cfg_t c,
		input logic [5:0] s1, input logic [5:0] s2, input logic [7:0] sd);
		bdt_hit_t h;
		logic sig_in;
		logic [8:0] off;
		h = '0;
		sig_in = 1'b0;
		off = pos - F2_B2;
		case (c.fmt)
			FMT_ONE: begin
				if (pos < F1_B2) begin
					h.b1 = 1'b1;
				end else if (pos < F1_SIG) begin
					h.b2 = 1'b1;
				end else if (pos < F1_END) begin
					sig_in = 1'b1;
				end
				h.idx = pos[2:0];
				h.sidx = pos[0];
			end
			FMT_TWO: begin
				if (pos < F2_SIG1) begin
					h.b1 = 1'b1;
					h.idx = pos[2:0];
				end else if (pos == F2_SIG1) begin
					sig_in = 1'b1;
					h.sidx = 1'b0;
				end else if (pos >= F2_B2 && pos < F2_SIG2) begin
					h.b2 = 1'b1;
					h.idx = off[2:0];
				end else if (pos == F2_SIG2) begin
					sig_in = 1'b1;
					h.sidx = 1'b1;
				end
			end
			FMT_THREE: begin
				h.idx = pos[2:0];
				h.sidx = pos[0];
				if (pos[8:3] == s1) begin
					h.b1 = 1'b1;
				end else if (pos[8:3] == s2) begin
					h.b2 = 1'b1;
				end else if (pos[8:1] == sd) begin
					sig_in = 1'b1;
				end
			end
			default: begin
				if (pos < F4_B2) begin
					h.b1 = 1'b1;
				end else if (pos < F4_GAP) begin
					h.b2 = 1'b1;
				end else if (pos >= F4_SIG && pos < F4_END) begin
					sig_in = 1'b1;
				end
				h.idx = pos[2:0];
				h.sidx = pos[0];
			end
		endcase
		if (sig_in) begin
			if (!c.sig_port_en) begin
				h.sigm = 1'b1;
			end else if (c.sig_port_bclk) begin
				h.sigp = 1'b1;
			end
		end
		map_pos = h;
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		bdt_hit_t ht;
		bdt_hit_t hr;
		bdt_frame_t cur_rx;
		logic rise;
		logic fall;
		logic dly;
		logic st_tx;
		logic st_rx;
		logic drise;
		logic dfall;
		logic [8:0] ptx;
		logic [8:0] prx;
		logic [8:0] b2s;
		ht = '0;
		hr = '0;
		cur_rx = s_reg.rx_word;
		rise = 1'b0;
		fall = 1'b0;
		drise = 1'b0;
		dfall = 1'b0;
		st_tx = 1'b0;
		st_rx = 1'b0;
		ptx = 9'h000;
		prx = 9'h000;
		s_next = s_reg;
		s_next.tx_push = 1'b0;
		s_next.rx_pop = 1'b0;
		s_next.strobe_o = 1'b0;
		dly = (cfg.fmt == FMT_TWO) ? 1'b1 : (cfg.fmt == FMT_FOUR) ? 1'b0 : cfg.delayed;
		b2s = (cfg.fmt == FMT_TWO) ? F2_B2 : F1_B2;

		if (cfg.master) begin
			if (s_reg.bdiv == MASTER_HALF_M1) begin
				s_next.bdiv = 5'h00;
				s_next.bclk_o = ~s_reg.bclk_o;
				rise = ~s_reg.bclk_o;
				fall = s_reg.bclk_o;
			end else begin
				s_next.bdiv = s_reg.bdiv + 5'h01;
			end
		end else begin
			s_next.bdiv = 5'h00;
			s_next.bclk_o = 1'b0;
			rise = pin.bclk & ~s_reg.bclk_prev;
			fall = ~pin.bclk & s_reg.bclk_prev;
		end
		s_next.bclk_prev = pin.bclk;
		s_next.bclk_oe = cfg.master;
		s_next.fs_oe = cfg.master;

		// frame sync history for slave detection
		if (rise) begin
			s_next.fsa_r = pin.frame_sync_a;
			s_next.fsb_r = pin.frame_sync_b;
		end
		if (fall) begin
			s_next.fsa_f1 = pin.frame_sync_a;
			s_next.fsa_f2 = s_reg.fsa_f1;
			s_next.fsb_f1 = pin.frame_sync_b;
			s_next.fsb_f2 = s_reg.fsb_f1;
		end

		if (cfg.master) begin
			st_tx = (s_reg.tx_pos == MASTER_LAST) || !s_reg.tx_run;
			st_rx = st_tx;
		end else if (dly) begin
			st_tx = s_reg.fsa_f1 & ~s_reg.fsa_f2;
			st_rx = s_reg.fsb_f1 & ~s_reg.fsb_f2;
		end else begin
			st_tx = pin.frame_sync_a & ~s_reg.fsa_r;
			st_rx = pin.frame_sync_b & ~s_reg.fsb_r;
		end
		ptx = st_tx ? 9'h000 : (s_reg.tx_pos == POS_MAX) ? POS_MAX : s_reg.tx_pos + 9'h001;
		prx = st_rx ? 9'h000 : (s_reg.rx_pos == POS_MAX) ? POS_MAX : s_reg.rx_pos + 9'h001;

		if (rise) begin
			if (st_tx && s_reg.tx_run) begin
				s_next.tx_push = 1'b1;
				s_next.tx_out = s_reg.tx_word;
			end
			s_next.tx_pos = ptx;
			s_next.tx_run = st_tx | (s_reg.tx_run & (s_reg.tx_pos != POS_MAX));
			if (st_rx) begin
				s_next.rx_pop = 1'b1;
				cur_rx = rx_head;
				s_next.rx_word = rx_head;
			end
			s_next.rx_pos = prx;
			s_next.rx_run = st_rx | (s_reg.rx_run & (s_reg.rx_pos != POS_MAX));
			hr = map_pos(prx, cfg, s_reg.act.rx_b1, s_reg.act.rx_b2, s_reg.act.rx_sig);
			if (hr.b1) begin
				s_next.brx_o = cur_rx.b1[~hr.idx];
			end else if (hr.b2) begin
				s_next.brx_o = cur_rx.b2[~hr.idx];
			end else begin
				s_next.brx_o = cur_rx.sig[~hr.sidx];
			end
			s_next.brx_oe = s_next.rx_run & (hr.b1 | hr.b2 | hr.sigm);
			// strobe pulls low in rx bearer slots
			s_next.strobe_oe = cfg.network_end & s_next.rx_run & (hr.b1 | hr.b2);
			if (!(cfg.sig_port_en && !cfg.sig_port_bclk)) begin
				s_next.srx_o = cur_rx.sig[~hr.sidx];
				s_next.srx_oe = s_next.rx_run & hr.sigp;
			end
			if (cfg.fmt == FMT_FOUR) begin
				s_next.fsa_o = ptx < MASTER_SQUARE;
				s_next.fsb_o = (ptx >= F4_B2) && (ptx < F4_GAP);
			end else if (dly) begin
				s_next.fsa_o = ptx == MASTER_LAST;
				s_next.fsb_o = ptx == (b2s - 9'h001);
			end else begin
				s_next.fsa_o = ptx < SLOT_BITS;
				s_next.fsb_o = (ptx >= b2s) && (ptx < (b2s + SLOT_BITS));
			end
		end
		if (!cfg.master) begin
			s_next.fsa_o = 1'b0;
			s_next.fsb_o = 1'b0;
		end
		if (!cfg.network_end) begin
			s_next.strobe_oe = 1'b0;
		end

		if (fall && s_reg.tx_run) begin
			ht = map_pos(s_reg.tx_pos, cfg, s_reg.act.tx_b1, s_reg.act.tx_b2, s_reg.act.tx_sig);
			if (ht.b1) begin
				s_next.tx_word.b1[~ht.idx] = pin.btx;
			end else if (ht.b2) begin
				s_next.tx_word.b2[~ht.idx] = pin.btx;
			end else if (ht.sigm) begin
				s_next.tx_word.sig[~ht.sidx] = pin.btx;
			end else if (ht.sigp) begin
				s_next.tx_word.sig[~ht.sidx] = pin.stx;
			end
		end

		if (cfg.sig_port_en && !cfg.sig_port_bclk) begin
			s_next.sclk_oe = 1'b1;
			if (s_reg.sdiv == SIG_HALF_M1) begin
				s_next.sdiv = 10'h000;
				s_next.sclk_o = ~s_reg.sclk_o;
				drise = ~s_reg.sclk_o;
				dfall = s_reg.sclk_o;
			end else begin
				s_next.sdiv = s_reg.sdiv + 10'h001;
			end
			s_next.srx_oe = 1'b1;
			if (drise) begin
				s_next.srx_o = s_reg.rx_word.sig[~s_reg.sbit];
			end
			if (dfall) begin
				s_next.tx_word.sig[~s_reg.sbit] = pin.stx;
				s_next.sbit = ~s_reg.sbit;
			end
		end else begin
			s_next.sclk_oe = 1'b0;
			s_next.sclk_o = 1'b0;
			s_next.sdiv = 10'h000;
			s_next.sbit = 1'b0;
		end

		if (rise && st_tx && s_reg.pend != 2'h0) begin
			s_next.pend = s_reg.pend - 2'h1;
			if (s_reg.pend == 2'h1) begin
				s_next.act = s_reg.shd;
			end
		end
		if (slot_wr.valid) begin
			s_next.pend = APPLY_FRAMES;
			if (slot_wr.sel == SEL_TX_B1) begin
				s_next.shd.tx_b1 = slot_wr.value[5:0];
			end else if (slot_wr.sel == SEL_TX_B2) begin
				s_next.shd.tx_b2 = slot_wr.value[5:0];
			end else if (slot_wr.sel == SEL_RX_B1) begin
				s_next.shd.rx_b1 = slot_wr.value[5:0];
			end else if (slot_wr.sel == SEL_RX_B2) begin
				s_next.shd.rx_b2 = slot_wr.value[5:0];
			end else if (slot_wr.sel == SEL_TX_SIG) begin
				s_next.shd.tx_sig = slot_wr.value;
			end else if (slot_wr.sel == SEL_RX_SIG) begin
				s_next.shd.rx_sig = slot_wr.value;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.act <= SLOTS_RST;
			s_reg.shd <= SLOTS_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	assign bit_clock_out = s_reg.bclk_o;
	assign bit_clock_oe = s_reg.bclk_oe;
	assign frame_sync_a_out = s_reg.fsa_o;
	assign frame_sync_a_oe = s_reg.fs_oe;
	assign frame_sync_b_out = s_reg.fsb_o;
	assign frame_sync_b_oe = s_reg.fs_oe;
	assign bearer_rx_out = s_reg.brx_o;
	assign bearer_rx_oe = s_reg.brx_oe;
	assign rx_slot_strobe_out = s_reg.strobe_o;
	assign rx_slot_strobe_oe = s_reg.strobe_oe;
	assign sig_rx_out = s_reg.srx_o;
	assign sig_rx_oe = s_reg.srx_oe;
	assign sig_port_clock_out = s_reg.sclk_o;
	assign sig_port_clock_oe = s_reg.sclk_oe;

endmodule

// *** testbench/bdt_port_assertions.sv ***
// Purpose: port-level checks on the time-slot engine
// Assumes: one clk_sys domain, rst_n synchronous active low
// Notes: spans are judged only once cfg has been steady for a while
`timescale 1ns/1ns
module bdt_port_assertions
	import bdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire bdt_cfg_t cfg,
	input wire logic bit_clock_in,
	input wire logic bit_clock_out,
	input wire logic bit_clock_oe,
	input wire logic frame_sync_a_out,
	input wire logic frame_sync_a_oe,
	input wire logic frame_sync_b_out,
	input wire logic bearer_rx_out,
	input wire logic bearer_rx_oe,
	input wire logic rx_slot_strobe_out,
	input wire logic rx_slot_strobe_oe,
	input wire logic sig_port_clock_out,
	input wire logic sig_port_clock_oe,
	input wire logic line_tick,
	input wire bdt_frame_t line_tx_word
);
	bdt_cfg_t cfg_q;
	logic bco_q, sco_q;
	logic [15:0] stb_cnt;
	logic [15:0] stb;
	logic [11:0] hc, sc, fa_n, fb_n;

	// steady count reads zero in the very cycle cfg moves
	assign stb = (cfg != cfg_q) ? 16'h0000 : stb_cnt;

	// ---------------------------------------------------------------
	// steady-config and span counters
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		cfg_q <= cfg;
		bco_q <= bit_clock_out;
		sco_q <= sig_port_clock_out;
		hc <= (bit_clock_out != bco_q) ? 12'h001 : hc + 12'h001;
		sc <= (sig_port_clock_out != sco_q) ? 12'h001 : sc + 12'h001;
		fa_n <= frame_sync_a_out ? fa_n + 12'h001 : 12'h000;
		fb_n <= frame_sync_b_out ? fb_n + 12'h001 : 12'h000;
		if (!rst_n || cfg != cfg_q) begin
			stb_cnt <= '0;
		end else if (stb_cnt != 16'hffff) begin
			stb_cnt <= stb_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_strobe_slot: assert property (
		rx_slot_strobe_oe && stb > 2 |-> bearer_rx_oe && cfg.network_end)
		else $error("strobe pulled outside a receive bearer bit");
	a_strobe_low: assert property (
		rx_slot_strobe_oe |-> !rx_slot_strobe_out) else $error("strobe driven high");
	a_reset_idle: assert property (
		$rose(rst_n) |-> !(bearer_rx_oe || bit_clock_oe || frame_sync_a_oe || rx_slot_strobe_oe))
		else $error("pin driven right after reset");
	a_master_drive: assert property (
		cfg.master && stb > 2 |-> bit_clock_oe && frame_sync_a_oe)
		else $error("master not driving clock and sync");
	a_bclk_half: assert property (
		cfg.master && bit_clock_oe && stb > 2000 && bit_clock_out != bco_q |-> hc == MASTER_HALF)
		else $error("master bit clock half period wrong");
	a_fsa_span: assert property (
		cfg.master && !cfg.delayed && cfg.fmt != FMT_TWO && stb > 4000 && $fell(frame_sync_a_out)
		|-> fa_n == ((cfg.fmt == FMT_FOUR) ? 12'h600 : 12'h180))
		else $error("master sync a width wrong");
	a_fsb_span: assert property (
		cfg.master && !cfg.delayed && cfg.fmt != FMT_TWO && stb > 4000 && $fell(frame_sync_b_out)
		|-> fb_n == 12'h180) else $error("master sync b width wrong");
	a_rx_on_rise: assert property (
		!cfg.master && stb > 8 && ($changed(bearer_rx_out) || $changed(bearer_rx_oe))
		|-> $past(bit_clock_in)) else $error("receive pin moved away from a rising edge");
	a_tick_word: assert property (
		$changed(line_tx_word) |-> $past(line_tick) || $past(line_tick, 2))
		else $error("line word changed without a pop");
	a_sig_clk: assert property (
		sig_port_clock_oe && stb > 2000 && sig_port_clock_out != sco_q |-> sc == SIG_HALF)
		else $error("signalling port clock half period wrong");

	c_master_frame: cover property (cfg.master && $fell(frame_sync_a_out));
	c_strobe: cover property (rx_slot_strobe_oe);
	c_sig_clk: cover property (sig_port_clock_oe && $rose(sig_port_clock_out));
endmodule

bind bdt_port bdt_port_assertions u_bdt_port_assertions (.clk_sys, .rst_n, .cfg, .bit_clock_in,
	.bit_clock_out, .bit_clock_oe, .frame_sync_a_out, .frame_sync_a_oe, .frame_sync_b_out,
	.bearer_rx_out, .bearer_rx_oe, .rx_slot_strobe_out, .rx_slot_strobe_oe,
	.sig_port_clock_out, .sig_port_clock_oe, .line_tick, .line_tx_word);

// *** testbench/bdt_far_end.sv ***
// Purpose: backplane timing source and bit sink facing the serial port
// Assumes: 64-bit frames of a 320 ns bit clock
// Notes: bit n is captured at the rise that ends it; undriven bits read as x
`timescale 1ns/1ns
module bdt_far_end (
	input wire logic delayed,
	input wire logic [31:0] txd,
	input wire logic rx,
	input wire logic rx_oe,
	input wire logic sig_rx,
	input wire logic sig_oe,
	output logic bclk,
	output logic fs_a,
	output logic fs_b,
	output logic tx,
	output logic [31:0] cap,
	output logic [31:0] msk
);
	int n;

	initial begin
		bclk = 1'b0;
		fs_a = 1'b0;
		fs_b = 1'b0;
		tx = 1'b0;
		n = 63;
		#13;
		forever begin
			#160;
			bclk = 1'b1;
			if (n < 32) begin
				cap[31-n] = rx_oe ? rx : (sig_oe ? sig_rx : 1'bx);
				msk[31-n] = rx_oe;
			end
			n = (n + 1) % 64;
			fs_a = delayed ? (n == 63) : (n < 8);
			fs_b = fs_a;
			tx = (n < 32) ? txd[31-n] : ~tx;
			#160;
			bclk = 1'b0;
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Purpose: frame-level tests of the time-slot engine in every format
// Assumes: far-end model supplies clock and syncs in slave runs
// Notes: line side pops and pushes once per frame, matched to the far end
`timescale 1ns/1ns
module testbench;
	import bdt_pkg::*;
	logic clk_sys, rst_n, line_tick, dly_m;
	logic bit_clock_in, bit_clock_out, bit_clock_oe, frame_sync_a_in, frame_sync_a_out;
	logic frame_sync_a_oe, frame_sync_b_in, frame_sync_b_out, frame_sync_b_oe, bearer_tx_in;
	logic bearer_rx_out, bearer_rx_oe, rx_slot_strobe_out, rx_slot_strobe_oe, sig_tx_in;
	logic sig_rx_out, sig_rx_oe, sig_port_clock_out, sig_port_clock_oe, tx_slip, rx_slip;
	logic [31:0] txd, cap, msk;
	logic [8:0] tcnt;
	bdt_cfg_t cfg;
	bdt_slot_wr_t slot_wr;
	bdt_frame_t line_rx_word, line_tx_word;
	int errors, n_tests;
	localparam bdt_frame_t W_RX = '{b1: 8'ha5, b2: 8'h3c, sig: 2'h1};
	localparam bdt_frame_t W_TX = '{b1: 8'h96, b2: 8'h0f, sig: 2'h2};

	assign sig_tx_in = bearer_tx_in;
	bdt_port u_bdt_port (.clk_sys, .rst_n, .cfg, .slot_wr, .bit_clock_in, .bit_clock_out,
		.bit_clock_oe, .frame_sync_a_in, .frame_sync_a_out, .frame_sync_a_oe, .frame_sync_b_in,
		.frame_sync_b_out, .frame_sync_b_oe, .bearer_tx_in, .bearer_rx_out, .bearer_rx_oe,
		.rx_slot_strobe_out, .rx_slot_strobe_oe, .sig_tx_in, .sig_rx_out, .sig_rx_oe,
		.sig_port_clock_out, .sig_port_clock_oe, .line_tick, .line_rx_word, .line_tx_word,
		.tx_slip, .rx_slip);
	bdt_far_end u_bdt_far_end (.delayed(dly_m), .txd(txd), .rx(bearer_rx_out),
		.rx_oe(bearer_rx_oe), .sig_rx(sig_rx_out), .sig_oe(sig_rx_oe), .bclk(bit_clock_in),
		.fs_a(frame_sync_a_in), .fs_b(frame_sync_b_in), .tx(bearer_tx_in), .cap(cap), .msk(msk));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic setc(bdt_cfg_t c);
		@(posedge clk_sys);
		cfg <= c;
	endtask

	task automatic write_slot(logic [2:0] sel, logic [7:0] v);
		@(posedge clk_sys);
		slot_wr <= '{valid: 1'b1, sel: sel, value: v};
		@(posedge clk_sys);
		slot_wr <= '0;
	endtask

	// returns expected {data, bearer-pin enables, all carried bits}, bit 0 of frame at [31]
	function automatic logic [95:0] lay(logic [1:0] f, bdt_frame_t w, int p2, logic sp);
		logic [31:0] d;
		logic [31:0] e;
		logic [31:0] s;
		int ps;
		d = '0;
		e = '0;
		s = '0;
		ps = (f == FMT_FOUR) ? 24 : 16;
		if (f == FMT_TWO) begin
			p2 = 10;
			d[23] = w.sig[1];
			d[13] = w.sig[0];
			s[23] = 1'b1;
			s[13] = 1'b1;
		end else begin
			d[31-ps-:2] = w.sig;
			s[31-ps-:2] = 2'h3;
		end
		d[31-:8] = w.b1;
		d[31-p2-:8] = w.b2;
		e[31-:8] = 8'hff;
		e[31-p2-:8] = 8'hff;
		return {d, sp ? e : (e | s), e | s};
	endfunction

	task automatic run(logic [1:0] f, logic dly, logic sp, int s2);
		logic [95:0] x;
		logic [95:0] y;
		logic sl;
		x = lay(f, W_RX, 8 * s2, sp);
		y = lay(f, W_TX, 8 * s2, sp);
		dly_m <= dly;
		txd <= y[95:64] | ~y[31:0];
		setc('{f, 1'b0, dly, sp, 1'b1, 1'b1});
		if (f == FMT_THREE) begin
			write_slot(SEL_RX_B2, 8'(s2));
			write_slot(SEL_TX_B2, 8'(s2));
		end
		repeat (2560) @(posedge clk_sys);
		sl = 1'b0;
		repeat (1024) begin
			@(negedge clk_sys);
			sl = sl | tx_slip | rx_slip;
		end
		check(64'(sl), 64'h0);
		check(64'(cap & x[31:0]), 64'(x[95:64] & x[31:0]));
		check(64'(msk), 64'(x[63:32]));
		check(64'(line_tx_word), 64'(W_TX));
	endtask

	// ---------------------------------------------------------------
	// clock, line side, watchdog, sequence
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		tcnt <= rst_n ? tcnt + 9'h001 : 9'h000;
		line_tick <= rst_n && (tcnt == 9'h000);
	end

	initial begin
		#2400000;
		errors++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		cfg = '0;
		slot_wr = '0;
		line_rx_word = W_RX;
		dly_m = 1'b0;
		txd = '0;
		errors = 0;
		n_tests = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(64'({bit_clock_oe, frame_sync_a_oe, bearer_rx_oe, sig_rx_oe}), 64'h0);
		run(FMT_ONE, 1'b0, 1'b0, 1);
		run(FMT_ONE, 1'b0, 1'b1, 1);
		run(FMT_TWO, 1'b1, 1'b0, 1);
		run(FMT_FOUR, 1'b0, 1'b0, 1);
		run(FMT_THREE, 1'b1, 1'b0, 3);
		run(FMT_ONE, 1'b0, 1'b0, 1);
		setc('{FMT_FOUR, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
		repeat (12000) @(posedge clk_sys);
		check(64'({bit_clock_oe, frame_sync_a_oe, frame_sync_b_oe}), 64'h7);
		setc('{FMT_ONE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
		repeat (8000) @(posedge clk_sys);
		check(64'(frame_sync_b_oe), 64'h1);
		setc('{FMT_ONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1});
		repeat (5000) @(posedge clk_sys);
		check(64'({sig_port_clock_oe, sig_rx_oe}), 64'h3);
		print_verdict();
	end
endmodule
